// [hdl/asc_clkdiv.sv]
// Converter clock divider producing a one-cycle tick enable
`timescale 1ns/10ps
`default_nettype none
`include "asc_defines.svh"
module asc_clkdiv (
	input wire logic clk_i, // System clock
	input wire logic rst_n_i, // Synchronous reset, active low
	input wire logic run_i, // Count while high, restart when low
	input wire logic [1:0] sel_i, // Divider select
	output logic tick_o // One-cycle converter clock enable
);
	import asc_pkg::*;

	asc_div_regs_type r_r;
	asc_div_regs_type r_nxt;
	logic [4:0] last;

	always_comb begin
		r_nxt = r_r;
		unique case (sel_i)
			`ASC_DIV_SEL_2: last = `ASC_DIV_2;
			`ASC_DIV_SEL_8: last = `ASC_DIV_8;
			// Undefined code falls back to the slowest rate, the safe one
			default: last = `ASC_DIV_32;
		endcase
		r_nxt.tick = 1'b0;
		if (!run_i) begin
			r_nxt.cnt = 5'h00;
		end else if (r_r.cnt >= last) begin
			r_nxt.cnt = 5'h00;
			r_nxt.tick = 1'b1;
		end else begin
			r_nxt.cnt = r_r.cnt + 5'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign tick_o = r_r.tick;

endmodule
`default_nettype wire

// [hdl/asc_ctrl.sv]
// Converter sequencing control with APB register access
`timescale 1ns/10ps
`default_nettype none
`include "asc_defines.svh"
module asc_ctrl #(
	parameter logic [4:0] CONV_TICKS = `ASC_CONV_TICKS
) (
	input wire logic clk_i, // System clock, 250 MHz
	input wire logic rst_n_i, // Synchronous reset, active low
	input wire logic psel_i, // APB select
	input wire logic penable_i, // APB enable
	input wire logic pwrite_i, // APB direction, high for write
	input wire logic [7:0] paddr_i, // APB byte address
	input wire logic [31:0] pwdata_i, // APB write data
	input wire logic [3:0] pstrb_i, // APB write byte strobes
	output logic [31:0] prdata_o, // APB read data
	output logic pready_o, // APB ready
	output logic pslverr_o, // APB error for unmapped address
	input wire logic [11:0] conv_data_i, // Converter raw result
	output logic conv_pwr_o, // Converter power enable
	output logic conv_rst_o, // Converter held in reset
	output logic conv_clk_o, // Converter clock enable pulse
	output logic conv_sample_o, // Converter running a conversion
	output logic [2:0] conv_chan_o, // Selected analog input
	output logic [4:0] pb_analog_o, // Port B line analog, digital off
	output logic conv_irq_o, // End of conversion request pulse
	output logic test_mode_o // Clock register test bit
);
	import asc_pkg::*;

	asc_regs_type r_r;
	asc_regs_type r_nxt;
	logic tick;
	logic div_run;
	logic setup;
	logic access;
	logic wr_ctrl;
	logic wr_clk;
	logic mapped;
	logic [5:0] idx;
	logic new_start;
	logic [7:0] ctrl_rd;
	logic [7:0] clk_rd;
	logic [7:0] rd_byte;

	assign div_run = r_r.st == ASC_CONV;

	asc_clkdiv u_div (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.run_i(div_run),
		.sel_i(r_r.clk_sel),
		.tick_o(tick)
	);

	// Registers sit on word boundaries at four times their index
	assign idx = paddr_i[7:2];
	assign setup = psel_i && !penable_i;
	// Ready is registered, so every access phase ends after one cycle
	assign access = psel_i && penable_i && r_r.pready;
	assign mapped = idx == `ASC_IDX_RES_LO || idx == `ASC_IDX_RES_HI ||
		idx == `ASC_IDX_CTRL || idx == `ASC_IDX_CLKSET;
	assign wr_ctrl = access && pwrite_i && pstrb_i[0] &&
		idx == `ASC_IDX_CTRL;
	assign wr_clk = access && pwrite_i && pstrb_i[0] &&
		idx == `ASC_IDX_CLKSET;
	assign new_start = wr_ctrl ? pwdata_i[`ASC_CTRL_START_BIT] : r_r.start;

	always_comb begin
		ctrl_rd = 8'h00;
		ctrl_rd[`ASC_CTRL_CHAN_LSB +: 3] = r_r.chan;
		ctrl_rd[`ASC_CTRL_PCR_LSB +: 3] = r_r.pcr;
		ctrl_rd[`ASC_CTRL_DONE_BIT] = r_r.done;
		ctrl_rd[`ASC_CTRL_START_BIT] = r_r.start;
		clk_rd = 8'h00;
		clk_rd[`ASC_CLK_SEL_LSB +: 2] = r_r.clk_sel;
		clk_rd[`ASC_CLK_TEST_BIT] = r_r.test;
	end

	always_comb begin
		unique case (idx)
			`ASC_IDX_RES_LO: rd_byte = {r_r.result[3:0], 4'h0};
			`ASC_IDX_RES_HI: rd_byte = r_r.result[11:4];
			`ASC_IDX_CTRL: rd_byte = ctrl_rd;
			`ASC_IDX_CLKSET: rd_byte = clk_rd;
			default: rd_byte = 8'h00;
		endcase
	end

	always_comb begin
		r_nxt = r_r;
		r_nxt.irq = 1'b0;
		r_nxt.conv_clk = 1'b0;

		// Bus answer: data and status prepared in setup, shown in access
		if (setup) begin
			r_nxt.pready = 1'b1;
			r_nxt.pslverr = !mapped;
			r_nxt.prdata = pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
		end else if (access) begin
			r_nxt.pready = 1'b0;
			r_nxt.pslverr = 1'b0;
		end

		// Result bytes take no write path at all
		if (wr_ctrl) begin
			r_nxt.chan = pwdata_i[`ASC_CTRL_CHAN_LSB +: 3];
			r_nxt.pcr = pwdata_i[`ASC_CTRL_PCR_LSB +: 3];
			r_nxt.start = new_start;
		end
		if (wr_clk) begin
			r_nxt.clk_sel = pwdata_i[`ASC_CLK_SEL_LSB +: 2];
			r_nxt.test = pwdata_i[`ASC_CLK_TEST_BIT];
		end

		r_nxt.pwr = r_nxt.pcr != 3'h0;
		for (int i = 0; i < `ASC_NUM_LINES; i++) begin
			r_nxt.analog[i] = 3'(i) < r_nxt.pcr;
		end

		unique case (r_r.st)
			ASC_IDLE: begin
				if (!r_r.start && new_start) begin
					r_nxt.st = ASC_ARMED;
					r_nxt.done = 1'b1;
				end
			end
			ASC_ARMED: begin
				if (!new_start) begin
					r_nxt.st = ASC_CONV;
					r_nxt.tick_cnt = 5'h00;
				end
			end
			ASC_CONV: begin
				if (!r_r.start && new_start) begin
					// A fresh rise aborts and rearms the converter
					r_nxt.st = ASC_ARMED;
					r_nxt.done = 1'b1;
				end else if (tick) begin
					r_nxt.conv_clk = 1'b1;
					if (r_r.tick_cnt == CONV_TICKS - 5'h01) begin
						r_nxt.st = ASC_IDLE;
						r_nxt.done = 1'b0;
						r_nxt.result = conv_data_i;
						r_nxt.irq = 1'b1;
					end else begin
						r_nxt.tick_cnt = r_r.tick_cnt + 5'h01;
					end
				end
			end
		endcase

		// Without power nothing converts; the done flag keeps its value
		if (!r_nxt.pwr && r_nxt.st != ASC_IDLE) begin
			r_nxt.st = ASC_IDLE;
		end
		r_nxt.conv_rst = r_nxt.st == ASC_ARMED;
		r_nxt.sample = r_nxt.st == ASC_CONV;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			r_r <= '0;
			r_r.chan <= 3'(`ASC_CTRL_RESET >> `ASC_CTRL_CHAN_LSB);
			r_r.pcr <= 3'(`ASC_CTRL_RESET >> `ASC_CTRL_PCR_LSB);
			r_r.done <= `ASC_DONE_RESET;
			r_r.clk_sel <= 2'(`ASC_CLKSET_RESET);
			r_r.st <= ASC_IDLE;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign prdata_o = r_r.prdata;
	assign pready_o = r_r.pready;
	assign pslverr_o = r_r.pslverr;
	assign conv_pwr_o = r_r.pwr;
	assign conv_rst_o = r_r.conv_rst;
	assign conv_clk_o = r_r.conv_clk;
	assign conv_sample_o = r_r.sample;
	assign conv_chan_o = r_r.chan;
	assign pb_analog_o = r_r.analog;
	assign conv_irq_o = r_r.irq;
	assign test_mode_o = r_r.test;

endmodule
`default_nettype wire

// [hdl/asc_defines.svh]
// Register map, field positions, reset values and timing counts
// Notes on behaviour
// - Result left-aligned: high byte bits 11..4, low byte upper nibble 3..0.
// - Both result bytes are read-only; writes leave the result alone.
// - Channel field bits 2..0 selects inputs 0..4; codes 5..7 unused.
// - Port field bits 5..3 value n makes port B lines 0..n-1 analog.
// - Analog lines lose digital function and pull-high resistor.
// - Converter powered off while port field is zero, on otherwise.
// - Start bit 7 rising resets converter and sets done flag to 1.
// - Start bit falling after its rise begins converting selected channel.
// - Conversion end clears done flag bit 6 and loads result bytes.
// - Conversion end raises the interrupt request; enabling is external.
// - Clock field bits 1..0 divide system clock by 2, 8 or 32.
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH

`define ASC_IDX_RES_LO 6'h20
`define ASC_IDX_RES_HI 6'h21
`define ASC_IDX_CTRL 6'h22
`define ASC_IDX_CLKSET 6'h23

`define ASC_CTRL_CHAN_LSB 0
`define ASC_CTRL_PCR_LSB 3
`define ASC_CTRL_DONE_BIT 6
`define ASC_CTRL_START_BIT 7
`define ASC_CLK_SEL_LSB 0
`define ASC_CLK_TEST_BIT 7

`define ASC_CTRL_RESET 8'h00
`define ASC_CLKSET_RESET 8'h00
`define ASC_DONE_RESET 1'b0

`define ASC_DIV_SEL_2 2'h0
`define ASC_DIV_SEL_8 2'h1
`define ASC_DIV_SEL_32 2'h2
`define ASC_DIV_2 5'h01
`define ASC_DIV_8 5'h07
`define ASC_DIV_32 5'h1f

`define ASC_CONV_TICKS 5'h10
`define ASC_NUM_LINES 5

`endif

// [hdl/asc_pkg.sv]
// Types shared by the converter control block
`default_nettype none
package asc_pkg;

	typedef enum logic [1:0] {
		ASC_IDLE = 2'h0,
		ASC_ARMED = 2'h1,
		ASC_CONV = 2'h3
	} asc_state_type;

	typedef struct packed {
		logic [4:0] cnt;
		logic tick;
	} asc_div_regs_type;

	typedef struct packed {
		logic [2:0] chan;
		logic [2:0] pcr;
		logic start;
		logic done;
		logic [1:0] clk_sel;
		logic test;
		logic [11:0] result;
		asc_state_type st;
		logic [4:0] tick_cnt;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
		logic conv_rst;
		logic conv_clk;
		logic sample;
		logic pwr;
		logic [4:0] analog;
	} asc_regs_type;

endpackage
`default_nettype wire

// [tb/asc_conv_model.sv]
// Behavioural analog side: a fixed code for each channel
`timescale 1ns/10ps
`default_nettype none
module asc_conv_model (
	input wire logic clk_i, // Clock
	input wire logic pwr_i, // Powered
	input wire logic rst_i, // Held in reset
	input wire logic [2:0] chan_i, // Channel
	output logic [11:0] data_o = 12'h5a5 // Result
);
	// Off or in reset the output churns, so a stale sample shows
	always @(posedge clk_i)
		if (!pwr_i || rst_i) data_o <= ~data_o;
		else data_o <= {chan_i, 9'h0b3};
endmodule
`default_nettype wire

// [tb/asc_ctrl_monitor.sv]
// Assertion checker for the converter control block
`timescale 1ns/10ps
`default_nettype none
module asc_ctrl_monitor #(
	parameter logic [4:0] CONV_TICKS = 5'h10
) (
	input wire logic clk_i, // Clock
	input wire logic rst_n_i, // Reset
	input wire logic psel_i, // APB
	input wire logic penable_i, // APB
	input wire logic pwrite_i, // APB
	input wire logic [7:0] paddr_i, // APB
	input wire logic [31:0] prdata_o, // APB
	input wire logic pready_o, // APB
	input wire logic conv_pwr_o, // Power
	input wire logic conv_rst_o, // Armed
	input wire logic conv_clk_o, // Tick
	input wire logic conv_sample_o, // Running
	input wire logic [4:0] pb_analog_o, // Lines
	input wire logic conv_irq_o // End
);
	logic [4:0] ticks_r;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Ticks of the running conversion; the last may share the end cycle
	always_ff @(posedge clk_i)
		if (!rst_n_i || conv_rst_o || conv_irq_o) ticks_r <= 5'h00;
		else if (conv_clk_o) ticks_r <= ticks_r + 5'h01;
	a_zero_wait: assert property (psel_i && !penable_i |=> pready_o)
		else $error("no ready");
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready held");
	a_unused_zero: assert property (pready_o && !pwrite_i &&
		paddr_i[7:2] == 6'h23 |-> prdata_o[6:2] == 5'h00)
		else $error("unused bits");
	a_lines_therm: assert property (
		(pb_analog_o & (pb_analog_o + 5'h01)) == 5'h00)
		else $error("lines gap");
	a_power_lines: assert property (
		conv_pwr_o == (pb_analog_o != 5'h00)) else $error("power");
	a_arm_idle: assert property (conv_rst_o |-> !conv_sample_o)
		else $error("armed run");
	a_start_conv: assert property (
		$fell(conv_rst_o) && conv_pwr_o |-> conv_sample_o)
		else $error("no start");
	a_end_irq: assert property (
		conv_irq_o |-> !conv_sample_o && $past(conv_sample_o))
		else $error("irq");
	a_tick_gap: assert property (conv_clk_o |=> !conv_clk_o)
		else $error("tick gap");
	a_tick_count: assert property (
		conv_irq_o |-> ticks_r + 5'(conv_clk_o) == CONV_TICKS)
		else $error("tick count");
	c_end: cover property (conv_irq_o);
	c_arm: cover property ($rose(conv_rst_o));
	c_all: cover property (pb_analog_o == 5'h1f);
endmodule
bind asc_ctrl asc_ctrl_monitor #(.CONV_TICKS(CONV_TICKS)) i_mon (.*);
`default_nettype wire

// [tb/asc_ctrl_tb.sv]
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module asc_ctrl_tb;
	localparam logic [4:0] CT = 5'h02;
	logic clk_i = 0, rst_n_i = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00, pwdata = 8'h00;
	logic [31:0] prdata;
	logic pready, pslverr, pwr, arm, tick, smp, irq, tmode;
	logic [2:0] chan;
	logic [4:0] lines;
	logic [11:0] cdata;
	int n_errors = 0, check_count = 0, cyc = 0;
	initial forever #2 clk_i = ~clk_i;
	asc_ctrl #(.CONV_TICKS(CT)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i({24'h0, pwdata}), .pstrb_i(4'h1),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.conv_data_i(cdata), .conv_pwr_o(pwr), .conv_rst_o(arm),
		.conv_clk_o(tick), .conv_sample_o(smp), .conv_chan_o(chan),
		.pb_analog_o(lines), .conv_irq_o(irq), .test_mode_o(tmode));
	asc_conv_model i_model (.clk_i(clk_i), .pwr_i(pwr), .rst_i(arm),
		.chan_i(chan), .data_o(cdata));
	task automatic wrap_up();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			wrap_up();
		end
	end
	task automatic apb(input logic w, input logic [7:0] a, d,
		output logic [7:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do @(posedge clk_i); while (pready !== 1'b1);
		r = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, d);
		logic [7:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		repeat (2) @(posedge clk_i);
	endtask
	task automatic t_regs();
		logic [7:0] r;
		logic e;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'h80 + 8'(4 * i), 8'h00, r, e);
			`CHK({e, r}, 9'h000)
		end
		apb(1'b1, 8'h90, 8'h55, r, e);
		apb(1'b0, 8'h90, 8'h00, r, e);
		`CHK({e, r}, 9'h100)
		$display("t_regs done");
	endtask
	task automatic t_ports();
		for (int n = 5; n >= 0; n--) begin
			wr(8'h88, 8'(n * 8 + n % 5));
			`CHK(lines, 5'((1 << n) - 1))
			`CHK(pwr, 1'(n != 0))
			`CHK(chan, 3'(n % 5))
			if (n != 0) begin
				// A nonzero port change must be followed by a start pulse
				wr(8'h88, 8'(8'h80 + n * 8 + n % 5));
				wr(8'h88, 8'(n * 8 + n % 5));
			end
		end
		$display("t_ports done");
	endtask
	task automatic t_conv(input int i);
		logic [7:0] r;
		logic e;
		int k, dv;
		logic [11:0] v;
		dv = (i % 3 == 0) ? 2 : (i % 3 == 1) ? 8 : 32;
		v = {3'(i), 9'h0b3};
		wr(8'h8c, 8'h7c | 8'(i % 3));
		apb(1'b0, 8'h8c, 8'h00, r, e);
		`CHK({tmode, r}, 9'(i % 3))
		wr(8'h88, 8'h28 | 8'(i));
		wr(8'h88, 8'ha8 | 8'(i));
		`CHK(arm, 1'b1)
		apb(1'b0, 8'h88, 8'h00, r, e);
		`CHK(r, 8'he8 | 8'(i))
		wr(8'h88, 8'h28 | 8'(i));
		k = 0;
		while (irq !== 1'b1) begin
			@(posedge clk_i);
			k++;
		end
		`CHK(k >= CT * dv - 2 && k <= CT * dv + 4, 1'b1)
		apb(1'b0, 8'h88, 8'h00, r, e);
		`CHK(r, 8'h28 | 8'(i))
		wr(8'h80, 8'hff);
		apb(1'b0, 8'h80, 8'h00, r, e);
		`CHK(r, {v[3:0], 4'h0})
		apb(1'b0, 8'h84, 8'h00, r, e);
		`CHK(r, v[11:4])
		$display("t_conv %0d done", i);
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		t_regs();
		t_ports();
		for (int i = 0; i < 5; i++)
			t_conv(i);
		wrap_up();
	end
endmodule
`default_nettype wire
